// File: src/reg_policy_pkg.sv
package reg_policy_pkg;

  // ----------------------------------------------------------------
  // widths and types
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int IDX_W       = ADDR_W - 2;
  localparam int WORD_STRIDE = 4;
  typedef logic [31:0] word_t;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTX    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WORD0  = 8'h10;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int    CTRL_COUNT_EN   = 0;
  localparam int    CTRL_CTX_SEL    = 1;
  localparam int    CTRL_INDIRECT   = 2;
  localparam word_t CTRL_RW_MASK    = 32'h0000_0003;
  localparam word_t CTRL_RESET      = 32'h0000_0000;
  localparam int    STAT_WRAP       = 0;
  localparam int    STAT_CNT_LSB    = 8;
  localparam word_t STAT_ONE_MASK   = 32'hFF00_0000;
  localparam word_t STAT_ZERO_MASK  = 32'h00FF_00FE;
  localparam int    CTX_FIELD_LSB   = 8;
  localparam int    CTX_FIELD_W     = 8;
  localparam word_t CTX_RW_MASK     = 32'h0000_FFFF;
  localparam word_t CTX_CTXRES_MASK = 32'h0000_FF00;
  localparam word_t CTX_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // default per-bit policy of the generic words
  // ----------------------------------------------------------------
  localparam word_t DEF_ZERO_MASK     = 32'hFF00_0000;
  localparam word_t DEF_ONE_MASK      = 32'h00FF_0000;
  localparam word_t DEF_RES_ZERO_MASK = 32'h0000_F000;
  localparam word_t DEF_RES_ONE_MASK  = 32'h0000_0F00;
  localparam word_t DEF_HARD_MASK     = 32'h0000_CC00;
  localparam word_t DEF_WORD_RESET    = 32'h0000_0F00;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic word_t lane_mask(input logic [3:0] be);
    word_t m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [ADDR_W-1:0] off);
    return idx == off[ADDR_W-1:2];
  endfunction

endpackage

// File: src/acc_if.sv
`timescale 1ns/1ps
interface acc_if;
  import reg_policy_pkg::*;

  logic             rd;
  logic             wr;
  logic [IDX_W-1:0] idx;
  word_t            wdata;
  logic [3:0]       be;
  word_t            rdata;

  modport front (output rd, wr, idx, wdata, be, input rdata);
  modport bank  (input rd, wr, idx, wdata, be, output rdata);
endinterface

// File: src/avmm_front.sv
`timescale 1ns/1ps
module avmm_front (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  // avalon slave side
  input  wire logic [reg_policy_pkg::ADDR_W-1:0] address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire reg_policy_pkg::word_t              writedata,
  input  wire logic [3:0]                         byteenable,
  output reg_policy_pkg::word_t                   readdata,
  output logic                                    waitrequest,
  // bank side
  acc_if.front                                    acc
);
  import reg_policy_pkg::*;

  logic take;

  // one access per request: waitrequest low for exactly one cycle
  assign take        = (read || write) && waitrequest;
  assign acc.rd      = read && waitrequest;
  assign acc.wr      = write && !read && waitrequest;
  assign acc.idx     = address[ADDR_W-1:2];
  assign acc.wdata   = writedata;
  assign acc.be      = byteenable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !take;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (acc.rd) begin
      readdata <= acc.rdata;
    end
  end

  a_wait_answer: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

endmodule

// File: src/policy_word.sv
`timescale 1ns/1ps
module policy_word #(
  parameter reg_policy_pkg::word_t ZERO_RD   = '0,
  parameter reg_policy_pkg::word_t ONE_RD    = '0,
  parameter reg_policy_pkg::word_t RES_ZERO  = '0,
  parameter reg_policy_pkg::word_t RES_ONE   = '0,
  parameter reg_policy_pkg::word_t HARDWIRED = '0,
  parameter reg_policy_pkg::word_t RESET_VAL = '0
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // access
  input  wire logic                  wrEn,
  input  wire logic                  indirectWr,
  input  wire reg_policy_pkg::word_t wdata,
  input  wire reg_policy_pkg::word_t wmask,
  output reg_policy_pkg::word_t      rdata,
  output reg_policy_pkg::word_t      funcBits
);
  import reg_policy_pkg::*;

  localparam word_t RES_ANY = RES_ZERO | RES_ONE;
  localparam word_t FIXED   = ZERO_RD | ONE_RD | (RES_ANY & HARDWIRED);
  localparam word_t STORED  = ~FIXED;
  localparam word_t RES_W   = RES_ANY & ~HARDWIRED;
  localparam word_t FUNC    = STORED & ~RES_ANY;

  word_t store_r;

  // fixed bits are masked out of every store_r load and stay 0, so a write cannot reach them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_r <= RESET_VAL & STORED;
    end else if (wrEn) begin
      store_r <= (store_r & ~(wmask & STORED)) | (wdata & wmask & STORED);
    end else if (indirectWr) begin
      store_r <= (store_r & ~RES_W) | (RES_ONE & RES_W);
    end
  end

  assign rdata    = (store_r & STORED) | ONE_RD | (RES_ONE & HARDWIRED);
  assign funcBits = store_r & FUNC;

  a_fixed_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (rdata & FIXED) == (ONE_RD | (RES_ONE & HARDWIRED)))
    else $error("fixed bit read back a wrong value");

  a_indirect_sets: assert property (@(posedge clk) disable iff (!rst_n)
    indirectWr && !wrEn |=> (store_r & RES_W) == (RES_ONE & RES_W))
    else $error("indirect write did not load reserved defaults");

  a_direct_store: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn |=> ((rdata ^ $past(wdata)) & $past(wmask) & STORED) == '0)
    else $error("written bit does not read back");

endmodule

// File: src/reserved_field_policy_regs.sv
`timescale 1ns/1ps
module reserved_field_policy_regs #(
  parameter int NUM_WORDS = 4,
  parameter int CNT_W     = 8,
  parameter reg_policy_pkg::word_t ZERO_MASK     [NUM_WORDS] = '{default: reg_policy_pkg::DEF_ZERO_MASK},
  parameter reg_policy_pkg::word_t ONE_MASK      [NUM_WORDS] = '{default: reg_policy_pkg::DEF_ONE_MASK},
  parameter reg_policy_pkg::word_t RES_ZERO_MASK [NUM_WORDS] = '{default: reg_policy_pkg::DEF_RES_ZERO_MASK},
  parameter reg_policy_pkg::word_t RES_ONE_MASK  [NUM_WORDS] = '{default: reg_policy_pkg::DEF_RES_ONE_MASK},
  parameter reg_policy_pkg::word_t HARD_MASK     [NUM_WORDS] = '{default: reg_policy_pkg::DEF_HARD_MASK},
  parameter reg_policy_pkg::word_t WORD_RESET    [NUM_WORDS] = '{default: reg_policy_pkg::DEF_WORD_RESET}
) (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  // avalon-mm register bus
  input  wire logic [reg_policy_pkg::ADDR_W-1:0]     address,
  input  wire logic                                   read,
  input  wire logic                                   write,
  input  wire reg_policy_pkg::word_t                  writedata,
  input  wire logic [3:0]                             byteenable,
  output wire reg_policy_pkg::word_t                  readdata,
  output wire logic                                   waitrequest,
  // indirect write source
  input  wire logic                                   indirectWr,
  // functional outputs
  output logic [NUM_WORDS*32-1:0]                     funcOut,
  output logic [reg_policy_pkg::CTX_FIELD_W-1:0]      ctxOut,
  output logic                                        countRun,
  output logic                                        wrapFlag
);
  import reg_policy_pkg::*;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  acc_if bus ();

  avmm_front u_front (
    .clk         (clk),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .acc         (bus.front)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  word_t wmask;
  logic  ctrlWr;
  logic  statusWr;
  logic  ctxWr;
  logic  ctrlRd;
  logic  statusRd;
  logic  indirectCmd;
  logic  indirectPulse;

  assign wmask    = lane_mask(bus.be);
  assign ctrlWr   = bus.wr && hit(bus.idx, OFF_CTRL);
  assign statusWr = bus.wr && hit(bus.idx, OFF_STATUS);
  assign ctxWr    = bus.wr && hit(bus.idx, OFF_CTX);
  assign ctrlRd   = bus.rd && hit(bus.idx, OFF_CTRL);
  assign statusRd = bus.rd && hit(bus.idx, OFF_STATUS);

  // command bit is a strobe, not storage, so it always reads back 0
  assign indirectCmd   = ctrlWr && wmask[CTRL_INDIRECT] && bus.wdata[CTRL_INDIRECT];
  assign indirectPulse = indirectCmd || indirectWr;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  word_t ctrl_r;
  word_t ctrl_nxt;
  logic  ctxReserved;

  always_comb begin
    ctrl_nxt = (ctrl_r & ~(wmask & CTRL_RW_MASK)) | (bus.wdata & wmask & CTRL_RW_MASK);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ctxReserved = ctrl_r[CTRL_CTX_SEL];

  // ----------------------------------------------------------------
  // counter and sticky wrap flag
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_r;
  logic             wrap_r;
  logic             wrapEvent;
  logic             wrapClr;

  assign wrapEvent = ctrl_r[CTRL_COUNT_EN] && (&count_r);
  assign wrapClr   = statusWr && wmask[STAT_WRAP] && bus.wdata[STAT_WRAP];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (ctrl_r[CTRL_COUNT_EN]) begin
      count_r <= count_r + 1'b1;
    end
  end

  // a wrap in the clearing cycle must not be lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_r <= 1'b0;
    end else if (wrapEvent) begin
      wrap_r <= 1'b1;
    end else if (wrapClr) begin
      wrap_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // context register
  // ----------------------------------------------------------------
  word_t ctx_r;
  word_t ctx_nxt;

  always_comb begin
    ctx_nxt = (ctx_r & ~(wmask & CTX_RW_MASK)) | (bus.wdata & wmask & CTX_RW_MASK);
  end

  // field is stored the same way in either context, so readback never
  // depends on which use the register had when it was written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctx_r <= CTX_RESET;
    end else if (ctxWr) begin
      ctx_r <= ctx_nxt;
    end else if (indirectPulse && ctxReserved) begin
      ctx_r <= ctx_r & ~CTX_CTXRES_MASK;
    end
  end

  // ----------------------------------------------------------------
  // generic policy words
  // ----------------------------------------------------------------
  word_t wordRd   [NUM_WORDS];
  word_t wordFunc [NUM_WORDS];
  logic  wordHit  [NUM_WORDS];

  for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
    assign wordHit[i] = hit(bus.idx, OFF_WORD0 + ADDR_W'(WORD_STRIDE * i));

    policy_word #(
      .ZERO_RD   (ZERO_MASK[i]),
      .ONE_RD    (ONE_MASK[i]),
      .RES_ZERO  (RES_ZERO_MASK[i]),
      .RES_ONE   (RES_ONE_MASK[i]),
      .HARDWIRED (HARD_MASK[i]),
      .RESET_VAL (WORD_RESET[i])
    ) u_word (
      .clk        (clk),
      .rst_n      (rst_n),
      .wrEn       (bus.wr && wordHit[i]),
      .indirectWr (indirectPulse),
      .wdata      (bus.wdata),
      .wmask      (wmask),
      .rdata      (wordRd[i]),
      .funcBits   (wordFunc[i])
    );
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  word_t rdMux;

  always_comb begin
    rdMux = '0;
    if (hit(bus.idx, OFF_CTRL)) begin
      rdMux = ctrl_r & CTRL_RW_MASK;
    end else if (hit(bus.idx, OFF_STATUS)) begin
      rdMux = STAT_ONE_MASK | (word_t'(count_r) << STAT_CNT_LSB) | word_t'(wrap_r);
    end else if (hit(bus.idx, OFF_CTX)) begin
      rdMux = ctx_r & CTX_RW_MASK;
    end else begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        if (wordHit[i]) begin
          rdMux = wordRd[i];
        end
      end
    end
  end

  assign bus.rdata = rdMux;

  // ----------------------------------------------------------------
  // functional outputs
  // ----------------------------------------------------------------
  // reserved bits are masked out before the flop, never after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      funcOut <= '0;
    end else begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        funcOut[i*32 +: 32] <= wordFunc[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctxOut <= '0;
    end else if (ctxReserved) begin
      ctxOut <= '0;
    end else begin
      ctxOut <= ctx_r[CTX_FIELD_LSB +: CTX_FIELD_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countRun <= 1'b0;
      wrapFlag <= 1'b0;
    end else begin
      countRun <= ctrl_r[CTRL_COUNT_EN];
      wrapFlag <= wrap_r;
    end
  end

  // ----------------------------------------------------------------
  // mapped-address decode
  // ----------------------------------------------------------------
  logic anyWordHit;
  logic mappedIdx;

  // word offsets are not assumed one-hot, so or every hit together
  always_comb begin
    anyWordHit = 1'b0;
    for (int i = 0; i < NUM_WORDS; i++) begin
      anyWordHit = anyWordHit | wordHit[i];
    end
  end

  assign mappedIdx = anyWordHit || hit(bus.idx, OFF_CTRL) || hit(bus.idx, OFF_STATUS) || hit(bus.idx, OFF_CTX);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_indirect_cmd;
    indirectCmd && !indirectWr;
  endsequence

  sequence s_ctx_cleared;
    (ctx_r & CTX_CTXRES_MASK) == '0;
  endsequence

  sequence s_ext_indirect;
    indirectWr && ctxReserved && !ctxWr;
  endsequence

  a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlRd |=> (readdata & ~CTRL_RW_MASK) == '0)
    else $error("reserved control bits read non-zero");

  a_status_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    statusRd |=> (readdata & STAT_ONE_MASK) == STAT_ONE_MASK && (readdata & STAT_ZERO_MASK) == '0)
    else $error("status fixed fields read wrong");

  a_wrap_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    wrapEvent |=> wrap_r ##1 wrapFlag)
    else $error("wrap event lost or not shown");

  a_wrap_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wrapClr && !wrapEvent |=> !wrap_r)
    else $error("write one did not clear the flag");

  a_wrap_keep: assert property (@(posedge clk) disable iff (!rst_n)
    wrap_r && !wrapClr |=> wrap_r)
    else $error("flag dropped without a clear");

  a_ctx_indirect: assert property (@(posedge clk) disable iff (!rst_n)
    s_indirect_cmd ##0 ctxReserved && !ctxWr |=> s_ctx_cleared)
    else $error("indirect write left context field set");

  a_ctx_no_effect: assert property (@(posedge clk) disable iff (!rst_n)
    ctxReserved |=> ctxOut == '0)
    else $error("reserved context field reached the output");

  a_ctx_readback: assert property (@(posedge clk) disable iff (!rst_n)
    ctxWr && wmask[CTX_FIELD_LSB] |=> ctx_r[CTX_FIELD_LSB] == $past(bus.wdata[CTX_FIELD_LSB]))
    else $error("context field lost a direct write");

  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_r[CTRL_COUNT_EN] |=> count_r == CNT_W'($past(count_r) + 1'b1))
    else $error("counter did not advance");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rd && !mappedIdx |=> readdata == '0)
    else $error("unmapped read returned non-zero");

  a_ctx_pulse_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_ext_indirect |=> s_ctx_cleared)
    else $error("indirect pulse left context field set");

  a_ctx_plain_keep: assert property (@(posedge clk) disable iff (!rst_n)
    indirectPulse && !ctxReserved && !ctxWr |=> $stable(ctx_r))
    else $error("indirect write changed context in plain use");

  a_ctx_plain_out: assert property (@(posedge clk) disable iff (!rst_n)
    !ctxReserved |=> ctxOut == $past(ctx_r[CTX_FIELD_LSB +: CTX_FIELD_W]))
    else $error("context field did not reach the output");

  a_count_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> countRun == $past(ctrl_r[CTRL_COUNT_EN]))
    else $error("run output does not follow control");

  a_wrap_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> wrapFlag == $past(wrap_r))
    else $error("wrap output does not follow the flag");

  a_ctrl_store: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr && wmask[CTRL_COUNT_EN] |=> ctrl_r[CTRL_COUNT_EN] == $past(bus.wdata[CTRL_COUNT_EN]))
    else $error("control write did not land");

  a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrlWr |=> $stable(ctrl_r))
    else $error("control changed without a write");

  a_status_count: assert property (@(posedge clk) disable iff (!rst_n)
    statusRd |=> readdata[STAT_CNT_LSB +: CNT_W] == $past(count_r))
    else $error("status counter field read wrong");

endmodule

// File: test/test_reserved_field_policy_regs.sv
`timescale 1ns/1ps
module test_reserved_field_policy_regs;
  import reg_policy_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   clk;
  logic                   rst_n;
  logic [ADDR_W-1:0]      address;
  logic                   read;
  logic                   write;
  word_t                  writedata;
  logic [3:0]             byteenable;
  word_t                  readdata;
  logic                   waitrequest;
  logic                   indirectWr;
  logic [127:0]           funcOut;
  logic [CTX_FIELD_W-1:0] ctxOut;
  logic                   countRun;
  logic                   wrapFlag;
  int                     errTotal;
  int                     nChecks;
  word_t                  rd;

  reserved_field_policy_regs u_dut (
    .clk         (clk),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .indirectWr  (indirectWr),
    .funcOut     (funcOut),
    .ctxOut      (ctxOut),
    .countRun    (countRun),
    .wrapFlag    (wrapFlag)
  );

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input word_t exp, input word_t got);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus_xfer(input logic isWr, input logic [ADDR_W-1:0] a, input word_t d,
                          input logic [3:0] be, output word_t q);
    @(posedge clk);
    address    <= a;
    read       <= !isWr;
    write      <= isWr;
    writedata  <= d;
    byteenable <= be;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'h0);
    q = readdata;
    read  <= 1'h0;
    write <= 1'h0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input word_t d, input logic [3:0] be);
    word_t q;
    bus_xfer(1'h1, a, d, be, q);
  endtask

  task automatic rdq(input logic [ADDR_W-1:0] a, output word_t q);
    bus_xfer(1'h0, a, 32'h0, 4'hF, q);
  endtask

  task automatic pulse_ind();
    @(posedge clk);
    indirectWr <= 1'h1;
    @(posedge clk);
    indirectWr <= 1'h0;
  endtask

  // outputs lag their register by one cycle
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdq(OFF_WORD0, rd);
    chk("word0 after reset", 32'h00FF_0F00, rd);
    rdq(OFF_STATUS, rd);
    chk("status after reset", 32'hFF00_0000, rd);
    chk("funcOut word0 after reset", 32'h0, funcOut[31:0]);
    $display("test reset done");
  endtask

  task automatic t_direct();
    wr(8'h14, 32'hFFFF_FFFF, 4'hF);
    rdq(8'h14, rd);
    chk("word1 all ones", 32'h00FF_3FFF, rd);
    settle();
    chk("funcOut word1", 32'h0000_00FF, funcOut[63:32]);
    wr(8'h14, 32'h0, 4'hF);
    rdq(8'h14, rd);
    chk("word1 all zeros", 32'h00FF_0C00, rd);
    // lanes: only the enabled byte may move
    wr(OFF_WORD0, 32'hFFFF_FFFF, 4'h1);
    rdq(OFF_WORD0, rd);
    chk("word0 lane0", 32'h00FF_0FFF, rd);
    wr(OFF_WORD0, 32'h0000_3000, 4'h2);
    rdq(OFF_WORD0, rd);
    chk("word0 lane1", 32'h00FF_3CFF, rd);
    $display("test direct done");
  endtask

  task automatic t_indirect();
    wr(8'h18, 32'h0000_3055, 4'hF);
    rdq(8'h18, rd);
    chk("word2 before indirect", 32'h00FF_3C55, rd);
    pulse_ind();
    rdq(8'h18, rd);
    chk("word2 after pulse", 32'h00FF_0F55, rd);
    wr(8'h18, rd, 4'hF);
    rdq(8'h18, rd);
    chk("word2 preserved", 32'h00FF_0F55, rd);
    rdq(8'h14, rd);
    chk("word1 after pulse", 32'h00FF_0F00, rd);
    wr(8'h1C, 32'h0000_3000, 4'hF);
    wr(OFF_CTRL, 32'h0000_0004, 4'hF);
    rdq(8'h1C, rd);
    chk("word3 after command", 32'h00FF_0F00, rd);
    rdq(OFF_CTRL, rd);
    chk("ctrl command bit", 32'h0, rd);
    $display("test indirect done");
  endtask

  task automatic t_ctx();
    wr(OFF_CTX, 32'h0000_ABCD, 4'hF);
    rdq(OFF_CTX, rd);
    chk("ctx plain use", 32'h0000_ABCD, rd);
    settle();
    chk("ctxOut plain use", 32'h0000_00AB, 32'(ctxOut));
    wr(OFF_CTRL, 32'h0000_0002, 4'hF);
    settle();
    chk("ctxOut reserved use", 32'h0, 32'(ctxOut));
    wr(OFF_CTX, 32'h0000_1234, 4'hF);
    wr(OFF_CTRL, 32'h0, 4'hF);
    rdq(OFF_CTX, rd);
    chk("ctx written while reserved", 32'h0000_1234, rd);
    settle();
    chk("ctxOut after use change", 32'h0000_0012, 32'(ctxOut));
    wr(OFF_CTRL, 32'h0000_0002, 4'hF);
    pulse_ind();
    rdq(OFF_CTX, rd);
    chk("ctx after indirect", 32'h0000_0034, rd);
    wr(OFF_CTX, 32'h0000_5678, 4'hF);
    wr(OFF_CTRL, 32'h0000_0006, 4'hF);
    rdq(OFF_CTX, rd);
    chk("ctx after command", 32'h0000_0078, rd);
    wr(OFF_CTRL, 32'h0, 4'hF);
    $display("test ctx done");
  endtask

  task automatic t_status();
    wr(OFF_CTRL, 32'h0000_0001, 4'hF);
    settle();
    chk("countRun", 32'h1, 32'(countRun));
    // 8-bit counter, so 300 cycles guarantee a wrap
    repeat (300) @(posedge clk);
    wr(OFF_CTRL, 32'h0, 4'hF);
    rdq(OFF_STATUS, rd);
    chk("status wrapped", 32'hFF00_0001, rd & 32'hFFFF_00FF);
    settle();
    chk("wrapFlag set", 32'h1, 32'(wrapFlag));
    wr(OFF_STATUS, 32'hFFFF_FFFE, 4'hF);
    rdq(OFF_STATUS, rd);
    chk("status write zero", 32'hFF00_0001, rd & 32'hFFFF_00FF);
    wr(OFF_STATUS, 32'h0000_0001, 4'hF);
    rdq(OFF_STATUS, rd);
    chk("status write one", 32'hFF00_0000, rd & 32'hFFFF_00FF);
    settle();
    chk("wrapFlag cleared", 32'h0, 32'(wrapFlag));
    $display("test status done");
  endtask

  task automatic t_unmapped();
    wr(8'h80, 32'hFFFF_FFFF, 4'hF);
    rdq(8'h80, rd);
    chk("unmapped 0x80", 32'h0, rd);
    rdq(8'h0C, rd);
    chk("unmapped 0x0C", 32'h0, rd);
    $display("test unmapped done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    errTotal   = 0;
    nChecks    = 0;
    rst_n      = 1'h0;
    address    = 8'h0;
    read       = 1'h0;
    write      = 1'h0;
    writedata  = 32'h0;
    byteenable = 4'h0;
    indirectWr = 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_direct();
    t_indirect();
    t_ctx();
    t_status();
    t_unmapped();
    end_of_test();
  end

  // whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
